// ---- rtl/lod_map.svh ----
// Register map constants for the lead-off detection control block.
// Assumes inclusion by the control module only; the package does not include it.
`ifndef LOD_MAP_SVH
`define LOD_MAP_SVH

// ----------------------------------------------------------------------
// Serial word layout
// ----------------------------------------------------------------------
`define LOD_FRAME_BITS     6'd32
`define LOD_HDR_LAST       6'd7
`define LOD_DATA_LAST      6'd31
`define LOD_RW_WRITE       1'b1
`define LOD_RW_READ        1'b0

// ----------------------------------------------------------------------
// Lead-off control register
// ----------------------------------------------------------------------
`define LOD_CTRL_ADDR      7'h02
`define LOD_CTRL_RESET     24'h000000
`define LOD_CTRL_WMASK     24'hE7919F
`define LOD_LEFT_ARM_PHASE   23
`define LOD_LEFT_LEG_PHASE   22
`define LOD_RIGHT_ARM_PHASE  21
`define LOD_CE_PHASE         18
`define LOD_LEFT_ARM_AC_EN   17
`define LOD_LEFT_LEG_AC_EN   16
`define LOD_RIGHT_ARM_AC_EN  15
`define LOD_CE_AC_EN         12
`define LOD_AC_LVL_HI        8
`define LOD_AC_LVL_LO        7
`define LOD_DC_LVL_HI        4
`define LOD_DC_LVL_LO        2
`define LOD_AC_SEL           1
`define LOD_DET_EN           0

`endif

// ---- rtl/lod_pkg.sv ----
// Types shared by the lead-off detection control block.
// Assumes lod_map.svh sits on the include path.
package lod_pkg;

	// ------------------------------------------------------------------
	// Serial pins; electrode order is left arm, left leg, right arm, common
	// ------------------------------------------------------------------
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic sdi;
	} lod_spi_in_t;

	typedef struct packed {
		logic sdo;
		logic sdo_oe;
	} lod_spi_out_t;

	typedef struct packed {
		logic [3:0] phase_invert;
		logic [3:0] ac_enable;
		logic [1:0] ac_drive_level;
		logic [2:0] dc_bias_level;
		logic       dc_enable;
		logic       detection_enable;
	} lod_detect_t;

	typedef enum logic {
		ST_IDLE,
		ST_SHIFT
	} lod_state_t;

endpackage

// ---- rtl/lod_pin_sync.sv ----
// Three-stage pin synchroniser with an agreement filter.
// Assumes asynchronous pins; the output changes once stages two and
// three agree, so a single metastable sample never reaches the logic.
module lod_pin_sync #(
	parameter int                 WIDTH       = 3,
	parameter logic [WIDTH-1:0]   RESET_LEVEL = '0
) (
	// Clock and reset.
	input  wire logic             clock,
	input  wire logic             rst_n,
	// Raw pins and filtered levels.
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);

	// ------------------------------------------------------------------
	// One filter per pin
	// ------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_pin
			logic s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;

			// Stage one feeds only stage two.
			always_comb begin
				lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
			end

			// Stages hold the reset level so idle pins read idle.
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					s1_reg  <= RESET_LEVEL[i];
					s2_reg  <= RESET_LEVEL[i];
					s3_reg  <= RESET_LEVEL[i];
					lvl_reg <= RESET_LEVEL[i];
				end else begin
					s1_reg  <= pin_in[i];
					s2_reg  <= s1_reg;
					s3_reg  <= s2_reg;
					lvl_reg <= lvl_next;
				end
			end

			assign level_out[i] = lvl_reg;
		end
	endgenerate

endmodule

// ---- rtl/lod_ctrl.sv ----
// Lead-off detection control register with its serial port.
// Assumes a serial clock well below a sixth of the 50 MHz system clock,
// idle low, data sampled on its rising edge, read data on its falling.
//
// Operation
// - Phase bits 23,22,21,18: zero in phase, one inverted by 180 degrees.
// - AC enables at 17,16,15,12; the three limb bits are ORed with the global ac select.
// - Bits 8:7 pick ac current 12.5, 25, 50 or 100 nA rms.
// - Bits 4:2 pick dc current in 10 nA steps, only when select is 0.
// - Global ac select enables right arm, left leg, left arm, never common.
// - Detection enable low turns detection off and ignores the select.
// - Enabled: select 0 gives dc plus per-bit ac, 1 gives ac only.
// - Calibration DAC enabled forces all ac detection off.
// - All fields reset to zero; reserved bits are written as zero.
// - Word: bit 31 read/write, 30:24 address, 23:0 data MSB first.
// - Register decodes at address 0x02 and resets to all zeros.
`include "lod_map.svh"

module lod_ctrl (
	// Clock and reset.
	input  wire logic         clock,
	input  wire logic         rst_n,
	// Software reset and calibration DAC state, same clock domain.
	input  wire logic         soft_reset,
	input  wire logic         cal_dac_enable,
	// Serial port pins.
	input  wire lod_pkg::lod_spi_in_t  spi_in,
	output lod_pkg::lod_spi_out_t      spi_out,
	// Detection controls towards the analog front end.
	output lod_pkg::lod_detect_t       detect_out
);
	import lod_pkg::*;

	// ------------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------------
	logic [2:0]   pins_f;
	logic         sclk_f, cs_active, sdi_f;
	lod_state_t   state_reg, state_next;
	logic [5:0]   cnt_reg, cnt_next;
	logic [31:0]  shift_reg, shift_next, shift_in;
	logic [23:0]  out_reg, out_next;
	logic [23:0]  ctrl_reg, ctrl_next;
	logic         rd_hit_reg, rd_hit_next, sclk_prev_reg;
	logic         sclk_rise, sclk_fall, wr_commit;
	lod_spi_out_t spi_reg, spi_next;
	lod_detect_t  det_reg, det_next;
	logic [3:0]   ac_bit, ac_term;

	// Chip select idles high, so its filter resets high.
	lod_pin_sync #(
		.WIDTH       (3),
		.RESET_LEVEL (3'b010)
	) u_sync (
		.clock     (clock),
		.rst_n     (rst_n),
		.pin_in    (spi_in),
		.level_out (pins_f)
	);

	// Edges are taken from the filtered level, never from a raw stage.
	assign sclk_f    = pins_f[2];
	assign cs_active = ~pins_f[1];
	assign sdi_f     = pins_f[0];
	assign sclk_rise = sclk_f & ~sclk_prev_reg;
	assign sclk_fall = ~sclk_f & sclk_prev_reg;
	assign shift_in  = {shift_reg[30:0], sdi_f};

	// A write lands only on the last bit of a full word to our address.
	assign wr_commit = (state_reg == ST_SHIFT) && cs_active && sclk_rise
		&& (cnt_reg == `LOD_DATA_LAST)
		&& (shift_in[31] == `LOD_RW_WRITE)
		&& (shift_in[30:24] == `LOD_CTRL_ADDR);

	// ------------------------------------------------------------------
	// Serial frame and register next state
	// ------------------------------------------------------------------
	// Bits past the thirty-second are ignored until chip select rises.
	always_comb begin
		state_next  = state_reg;
		cnt_next    = cnt_reg;
		shift_next  = shift_reg;
		out_next    = out_reg;
		rd_hit_next = rd_hit_reg;
		spi_next    = spi_reg;
		ctrl_next   = ctrl_reg;
		case (state_reg)
			ST_IDLE: begin
				if (cs_active) begin
					state_next  = ST_SHIFT;
					cnt_next    = 6'd0;
					rd_hit_next = 1'b0;
				end
			end
			ST_SHIFT: begin
				if (!cs_active) begin
					state_next  = ST_IDLE;
					rd_hit_next = 1'b0;
					spi_next    = '0;
				end else if (sclk_rise && cnt_reg != `LOD_FRAME_BITS) begin
					shift_next = shift_in;
					cnt_next   = cnt_reg + 6'd1;
					if (cnt_reg == `LOD_HDR_LAST
						&& shift_in[7] == `LOD_RW_READ
						&& shift_in[6:0] == `LOD_CTRL_ADDR) begin
						rd_hit_next = 1'b1;
						out_next    = ctrl_reg;
					end
					if (wr_commit) begin
						ctrl_next = shift_in[23:0] & `LOD_CTRL_WMASK;
					end
				end else if (sclk_fall && rd_hit_reg) begin
					spi_next.sdo    = out_reg[23];
					spi_next.sdo_oe = 1'b1;
					out_next        = {out_reg[22:0], 1'b0};
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// Software reset wins over a write in the same cycle.
		if (soft_reset) begin
			ctrl_next = `LOD_CTRL_RESET;
		end
	end

	// ------------------------------------------------------------------
	// Detection outputs
	// ------------------------------------------------------------------
	assign ac_bit = {ctrl_reg[`LOD_LEFT_ARM_AC_EN],
		ctrl_reg[`LOD_LEFT_LEG_AC_EN],
		ctrl_reg[`LOD_RIGHT_ARM_AC_EN], ctrl_reg[`LOD_CE_AC_EN]};

	// The global select reaches the three limb electrodes, not common.
	genvar e;
	generate
		for (e = 0; e < 4; e++) begin : g_elec
			if (e == 0) begin : g_ce
				assign ac_term[e] = ac_bit[e];
			end else begin : g_limb
				assign ac_term[e] = ac_bit[e] | ctrl_reg[`LOD_AC_SEL];
			end
		end
	endgenerate

	// Outputs are registered, so they follow the register by one cycle.
	always_comb begin
		det_next.phase_invert = {ctrl_reg[`LOD_LEFT_ARM_PHASE],
			ctrl_reg[`LOD_LEFT_LEG_PHASE],
			ctrl_reg[`LOD_RIGHT_ARM_PHASE],
			ctrl_reg[`LOD_CE_PHASE]};
		det_next.ac_enable = ac_term & {4{ctrl_reg[`LOD_DET_EN]
			& ~cal_dac_enable}};
		det_next.ac_drive_level =
			ctrl_reg[`LOD_AC_LVL_HI:`LOD_AC_LVL_LO];
		det_next.dc_enable = ctrl_reg[`LOD_DET_EN]
			& ~ctrl_reg[`LOD_AC_SEL];
		det_next.dc_bias_level = det_next.dc_enable
			? ctrl_reg[`LOD_DC_LVL_HI:`LOD_DC_LVL_LO] : 3'h0;
		det_next.detection_enable = ctrl_reg[`LOD_DET_EN];
	end

	// ------------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg     <= ST_IDLE;
			cnt_reg       <= 6'h0;
			shift_reg     <= 32'h0;
			out_reg       <= 24'h0;
			rd_hit_reg    <= 1'b0;
			sclk_prev_reg <= 1'b0;
			spi_reg       <= '0;
			ctrl_reg      <= `LOD_CTRL_RESET;
			det_reg       <= '0;
		end else begin
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			shift_reg     <= shift_next;
			out_reg       <= out_next;
			rd_hit_reg    <= rd_hit_next;
			sclk_prev_reg <= sclk_f;
			spi_reg       <= spi_next;
			ctrl_reg      <= ctrl_next;
			det_reg       <= det_next;
		end
	end

	assign spi_out    = spi_reg;
	assign detect_out = det_reg;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	chk_phase_follow: assert property (
		1'b1 |=> det_reg.phase_invert == $past({
		ctrl_reg[`LOD_LEFT_ARM_PHASE], ctrl_reg[`LOD_LEFT_LEG_PHASE],
		ctrl_reg[`LOD_RIGHT_ARM_PHASE], ctrl_reg[`LOD_CE_PHASE]}))
		else $error("phase outputs do not follow the register");
	chk_global_limbs: assert property (
		ctrl_reg[`LOD_DET_EN] && ctrl_reg[`LOD_AC_SEL] && !cal_dac_enable
		|=> det_reg.ac_enable[3:1] == 3'b111)
		else $error("global select did not enable limb ac detection");
	chk_level_follow: assert property (
		1'b1 |=> det_reg.ac_drive_level == $past(ctrl_reg[8:7]))
		else $error("ac drive level does not follow the register");
	chk_dc_gate: assert property (
		ctrl_reg[`LOD_DET_EN] && !ctrl_reg[`LOD_AC_SEL]
		|=> det_reg.dc_enable
		&& det_reg.dc_bias_level == $past(ctrl_reg[4:2]))
		else $error("dc detection not driven while select is zero");
	chk_common_excluded: assert property (
		!ctrl_reg[`LOD_CE_AC_EN] |=> !det_reg.ac_enable[0])
		else $error("common electrode ac enabled without its own bit");
	chk_disabled_off: assert property (
		!ctrl_reg[`LOD_DET_EN]
		|=> det_reg.ac_enable == 4'h0 && !det_reg.dc_enable
		&& det_reg.dc_bias_level == 3'h0)
		else $error("detection active while disabled");
	chk_cal_override: assert property (
		cal_dac_enable |=> det_reg.ac_enable == 4'h0)
		else $error("ac detection active with calibration DAC on");
	chk_reserved_zero: assert property (
		(ctrl_reg & ~`LOD_CTRL_WMASK) == 24'h0)
		else $error("reserved register bits are not zero");
	chk_soft_clear: assert property (
		soft_reset |=> ctrl_reg == `LOD_CTRL_RESET)
		else $error("software reset did not clear the register");
	chk_write_commit: assert property (
		wr_commit && !soft_reset
		|=> ctrl_reg == ($past(shift_in[23:0]) & `LOD_CTRL_WMASK))
		else $error("write word not stored");
	chk_read_shift: assert property (
		state_reg == ST_SHIFT && cs_active
		&& !sclk_rise && sclk_fall && rd_hit_reg
		|=> spi_reg.sdo == $past(out_reg[23]) && spi_reg.sdo_oe)
		else $error("read data bit not driven");

	cov_write: cover property (wr_commit);
	cov_read: cover property (rd_hit_reg && sclk_fall);
	cov_cal: cover property (ctrl_reg[`LOD_DET_EN] && cal_dac_enable);

endmodule

// ---- dv/lod_host.sv ----
// Serial host model that drives the lead-off control port.
// Assumes the 50 MHz system clock; sclk stands still between frames.
module lod_host (
	// Clock.
	input  wire logic                  clock,
	// Serial pins.
	output lod_pkg::lod_spi_in_t       spi_in,
	input  wire lod_pkg::lod_spi_out_t spi_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import lod_pkg::*;

	initial spi_in = 3'b010;

	// Sends the top nbits of a word MSB first, eight clocks per sclk phase,
	// and samples sdo at each rise of the 24 data bits. A short nbits aborts the frame. Idle sdi
	// shows the inverse of its last bit, so no stale value looks valid.
	task automatic xfer(input logic [31:0] word, input int nbits,
		output logic [23:0] rd, output logic oe);
		rd = 24'h000000;
		oe = 1'b0;
		@(posedge clock);
		spi_in.cs_n <= 1'b0;
		for (int i = 31; i > 31 - nbits; i--) begin
			@(posedge clock);
			spi_in.sdi  <= word[i];
			spi_in.sclk <= 1'b0;
			repeat (8) @(posedge clock);
			spi_in.sclk <= 1'b1;
			if (i < 24) begin
				rd[i] = spi_out.sdo;
				oe    = oe | spi_out.sdo_oe;
			end
			repeat (7) @(posedge clock);
		end
		@(posedge clock);
		spi_in.sclk <= 1'b0;
		spi_in.sdi  <= ~spi_in.sdi;
		repeat (8) @(posedge clock);
		spi_in.cs_n <= 1'b1;
		repeat (8) @(posedge clock);
	endtask
endmodule

// ---- dv/test_lod_ctrl.sv ----
// Self-checking bench for the lead-off detection control block.
// Assumes lod_pkg and the lod_host serial model are compiled first.
module test_lod_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import lod_pkg::*;

	logic         clock          = 1'b0;
	logic         rst_n          = 1'b0;
	logic         soft_reset     = 1'b0;
	logic         cal_dac_enable = 1'b0;
	lod_spi_in_t  spi_in;
	lod_spi_out_t spi_out;
	lod_detect_t  detect_out;
	int           err_total      = 0;
	int           total_checks   = 0;
	logic [23:0]  rd;
	logic         oe;
	logic [23:0]  cur;

	// 50 MHz clock.
	always #10 clock = ~clock;

	lod_ctrl lod_ctrl_i (.clock(clock), .rst_n(rst_n),
		.soft_reset(soft_reset), .cal_dac_enable(cal_dac_enable),
		.spi_in(spi_in), .spi_out(spi_out), .detect_out(detect_out));
	lod_host lod_host_i (.clock(clock), .spi_in(spi_in), .spi_out(spi_out));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Expected outputs; the dc level reads zero whenever dc is off.
	function automatic logic [23:0] exp_det(input logic [23:0] v,
		input logic cal);
		lod_detect_t d;
		d.phase_invert     = {v[23], v[22], v[21], v[18]};
		d.ac_enable        = (v[0] & ~cal) ?
			({v[17], v[16], v[15], v[12]} | {{3{v[1]}}, 1'b0}) : 4'h0;
		d.ac_drive_level   = v[8:7];
		d.dc_enable        = v[0] & ~v[1];
		d.dc_bias_level    = d.dc_enable ? v[4:2] : 3'h0;
		d.detection_enable = v[0];
		return 24'(d);
	endfunction

	task automatic check(input string name, input logic [23:0] exp,
		input logic [23:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [23:0] v, input int n);
		lod_host_i.xfer({1'b1, a, v}, n, rd, oe);
	endtask

	task automatic rd_reg(input logic [6:0] a);
		lod_host_i.xfer({1'b0, a, 24'h000000}, 32, rd, oe);
	endtask

	// Writes, then checks the outputs and the value read back.
	task automatic wr_chk(input logic [23:0] v);
		wr(7'h02, v, 32);
		cur = v;
		check("detect_out", exp_det(v, 1'b0), 24'(detect_out));
		rd_reg(7'h02);
		check("readback", v & 24'hE7919F, rd);
		check("sdo_oe", 24'h000001, 24'(oe));
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		check("detect_out", 24'h000000, 24'(detect_out));
		rd_reg(7'h02);
		check("reset value", 24'h000000, rd);
		check("reset oe", 24'h000001, 24'(oe));
	endtask

	// Every dc and ac code with dc on, phase and enables alternating.
	task automatic t_codes();
		logic [23:0] v;
		for (int k = 0; k < 8; k++) begin
			v = (24'(k) << 2) | (24'(k & 3) << 7) | 24'h000001 |
				(k[0] ? 24'hA48000 : 24'h441000);
			wr_chk(v);
		end
		wr_chk(24'hFFFFFF);
		wr_chk(24'h000003);
		wr_chk(24'h000002);
	endtask

	// Calibration DAC forces every ac enable off, then releases them.
	task automatic t_cal();
		wr_chk(24'h039003);
		cal_dac_enable <= 1'b1;
		repeat (4) @(posedge clock);
		check("cal on", exp_det(cur, 1'b1), 24'(detect_out));
		cal_dac_enable <= 1'b0;
		repeat (4) @(posedge clock);
		check("cal off", exp_det(cur, 1'b0), 24'(detect_out));
	endtask

	// Another address and an aborted frame must leave the register alone.
	task automatic t_refuse();
		wr(7'h03, 24'h000001, 32);
		check("other addr", exp_det(cur, 1'b0), 24'(detect_out));
		rd_reg(7'h03);
		check("other read", 24'h000000, rd);
		check("other oe", 24'h000000, 24'(oe));
		wr(7'h02, 24'h000001, 20);
		check("abort", exp_det(cur, 1'b0), 24'(detect_out));
	endtask

	task automatic t_soft();
		wr_chk(24'h000185);
		soft_reset <= 1'b1;
		@(posedge clock);
		soft_reset <= 1'b0;
		repeat (3) @(posedge clock);
		check("soft reset", 24'h000000, 24'(detect_out));
		rd_reg(7'h02);
		check("soft read", 24'h000000, rd);
		check("soft oe", 24'h000001, 24'(oe));
	endtask

	task automatic finish_test();
		$display("checks %0d, errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence after 20 clocks of reset and 6 of synchroniser settling.
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		repeat (6) @(posedge clock);
		t_reset();
		t_codes();
		t_cal();
		t_refuse();
		t_soft();
		finish_test();
	end

	// Watchdog: about 31 frames of some 530 clocks each, with margin.
	initial begin
		repeat (40000) @(posedge clock);
		err_total++;
		finish_test();
	end
endmodule
